//--- rtl/hspwm_pkg.sv
// package: register map, field positions and types for the high-speed pwm generator
// Functional notes
// - With the external period reset enable set, an external reset pulse restarts the channel time base, also while outputs are swapped.
// - In complementary mode the programmed dead time is inserted on every output transition, including ones caused at once by a duty write.
// - With immediate update, a duty write that lands between old and new duty switches outputs at once, through dead time in complementary mode.
// - Output control bits 11:10 select the pairing mode: 00 complementary, 01 redundant, 10 push-pull.
// - Channel control bit 8 picks the shared master duty instead of the channel duty.
// - In redundant or push-pull mode with buffered updates, a change to zero duty takes effect at the period boundary with no stray pulse.
// - Channel control bit 0 set applies duty writes at once; clear applies them at the next period boundary.
// - With override sync bit 0 clear, the two-bit override data takes effect on the next clock, not at a period boundary.
// - The generator runs only while master time base control bit 15 is set; software sets immediate enables first.
// - With buffered updates, a phase change below dead time or above duty still yields dead time at the next boundary.
// - Trigger compares fire on every (divider+1)th match of the programmed count after the first start-count matches, for values up to the period.
// - Trigger control bits 15:12 divide trigger outputs and bits 5:0 select the postscaler start count.
// - With immediate period update (bit 10), a period write at rollover never yields back-to-back push-pull pulses.
// - With immediate updates off, period, duty, phase and dead time written in one cycle all take effect together at the next cycle start.
package hspwm_pkg;
    localparam int CW = 16;
    localparam logic [7:0] OFS_MTB_CTRL = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_MASTER_DUTY = 8'h08;
    localparam logic [7:0] OFS_SEV_CMP = 8'h0C;
    localparam logic [7:0] OFS_CH_CTRL = 8'h10;
    localparam logic [7:0] OFS_CH_OUT_CTRL = 8'h14;
    localparam logic [7:0] OFS_CH_DUTY = 8'h18;
    localparam logic [7:0] OFS_CH_PHASE = 8'h1C;
    localparam logic [7:0] OFS_DEAD_TIME = 8'h20;
    localparam logic [7:0] OFS_TRIG_PRI = 8'h24;
    localparam logic [7:0] OFS_TRIG_SEC = 8'h28;
    localparam logic [7:0] OFS_TRIG_CTRL = 8'h2C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    localparam logic [7:0] OFS_STATE = 8'h38;
    localparam int MTB_EN_BIT = 15;
    localparam int MTB_IPU_BIT = 10;
    localparam int CC_IUE_BIT = 0;
    localparam int CC_XRST_BIT = 1;
    localparam int CC_MDUTY_BIT = 8;
    localparam int CC_INDEP_BIT = 9;
    localparam int OC_OVSYNC_BIT = 0;
    localparam int OC_SWAP_BIT = 1;
    localparam int OC_OVD_LO = 2;
    localparam int OC_OVEN_BIT = 4;
    localparam int OC_MODE_LO = 10;
    localparam int TC_DIV_LO = 12;
    localparam int TC_START_LO = 0;
    localparam logic [CW-1:0] PERIOD_RST = 16'h0064;
    localparam int IRQ_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        HSPWM_COMPL = 2'b00,
        HSPWM_REDUND = 2'b01,
        HSPWM_PUSHPULL = 2'b10
    } hspwm_mode_t;
    typedef struct packed {
        logic [CW-1:0] period;
        logic [CW-1:0] duty;
        logic [CW-1:0] phase;
        logic [CW-1:0] dead;
    } hspwm_timing_t;
    typedef struct packed {
        logic hi;
        logic lo;
    } hspwm_pair_t;
endpackage : hspwm_pkg

//--- rtl/hspwm_dead.sv
// dead-time inserter for one complementary output pair
`timescale 1ns/10ps
`default_nettype none
module hspwm_dead
    import hspwm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic run,
    input wire logic raw,
    input wire logic [CW-1:0] dead,
    output var hspwm_pair_t pair
);
    typedef struct packed {
        logic lvl;
        logic [CW-1:0] cnt;
        hspwm_pair_t out;
    } hspwm_dead_st_t;
    hspwm_dead_st_t s_q, s_d;

    // every edge of raw, however caused, goes through the dead count
    always_comb
    begin
        s_d = s_q;
        if (!run)
        begin
            s_d = '0;
        end
        else if (raw != s_q.lvl)
        begin
            s_d.lvl = raw;
            s_d.cnt = dead;
            s_d.out = '0;
        end
        else if (s_q.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
        else
        begin
            s_d.out.hi = s_q.lvl;
            s_d.out.lo = ~s_q.lvl;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign pair = s_q.out;

    no_overlap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(pair.hi && pair.lo)) else $error("both outputs high");
    dead_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && run && $past(run) && raw != s_q.lvl && dead != '0) |=> !pair.hi && !pair.lo)
        else $error("edge passed without dead time");
endmodule : hspwm_dead
`default_nettype wire

//--- rtl/hspwm_top.sv
// high-speed pwm channel with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
module hspwm_top
    import hspwm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic ext_reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic high_output,
    output logic low_output,
    output logic trig_out,
    output logic irq
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] mtb_ctrl;
        logic [15:0] chan_ctrl;
        logic [15:0] out_ctrl;
        logic [15:0] trig_ctrl;
        hspwm_timing_t wr;
        hspwm_timing_t act;
        logic [CW-1:0] master_duty;
        logic [CW-1:0] sev_cmp;
        logic [CW-1:0] trig_pri;
        logic [CW-1:0] trig_sec;
        logic [CW-1:0] cnt;
        logic pp_phase;
        logic [3:0] div_cnt;
        logic [5:0] start_cnt;
        logic trig;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic irq;
        hspwm_pair_t pins;
    } hspwm_st_t;
    hspwm_st_t s_q, s_d;

    logic run, raw, rollover, wr_fire, ext_hit;
    logic [CW-1:0] duty_sel, phase_sel;
    hspwm_mode_t mode;
    hspwm_pair_t dt_pair;
    logic [31:0] wmask;

    assign run = s_q.mtb_ctrl[MTB_EN_BIT];
    assign mode = hspwm_mode_t'(s_q.out_ctrl[OC_MODE_LO+:2]);
    // duty in use is always the active copy; selection of master duty below
    assign duty_sel = s_q.act.duty;
    assign phase_sel = s_q.act.phase;
    assign rollover = run && (s_q.cnt >= s_q.act.period);
    // swap does not gate the external reset
    assign ext_hit = run && s_q.chan_ctrl[CC_XRST_BIT] && ext_reset;
    // edge-aligned compare, shifted by phase except on the independent base
    always_comb
    begin
        if (s_q.chan_ctrl[CC_INDEP_BIT])
            raw = run && (s_q.cnt < duty_sel);
        else
            raw = run && ((s_q.cnt - phase_sel) < duty_sel) && (s_q.cnt >= phase_sel);
    end
    assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign wmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};

    hspwm_dead u_dead (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(run),
        .raw(raw),
        .dead(s_q.act.dead),
        .pair(dt_pair)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge16 = (old & ~m[15:0]) | (nw[15:0] & m[15:0]);
    endfunction : merge16

    always_comb
    begin
        logic [IRQ_W-1:0] ev;
        logic [CW-1:0] nd;
        ev = '0;
        nd = '0;
        s_d = s_q;
        // write channels, either order
        if (s_axi_awvalid && !s_q.aw_got)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        if (wr_fire)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.awaddr)
                OFS_MTB_CTRL: s_d.mtb_ctrl = merge16(s_q.mtb_ctrl, s_q.wdata, wmask);
                OFS_PERIOD: s_d.wr.period = merge16(s_q.wr.period, s_q.wdata, wmask);
                OFS_MASTER_DUTY: s_d.master_duty = merge16(s_q.master_duty, s_q.wdata, wmask);
                OFS_SEV_CMP: s_d.sev_cmp = merge16(s_q.sev_cmp, s_q.wdata, wmask);
                OFS_CH_CTRL: s_d.chan_ctrl = merge16(s_q.chan_ctrl, s_q.wdata, wmask);
                OFS_CH_OUT_CTRL: s_d.out_ctrl = merge16(s_q.out_ctrl, s_q.wdata, wmask);
                OFS_CH_DUTY: s_d.wr.duty = merge16(s_q.wr.duty, s_q.wdata, wmask);
                OFS_CH_PHASE: s_d.wr.phase = merge16(s_q.wr.phase, s_q.wdata, wmask);
                OFS_DEAD_TIME: s_d.wr.dead = merge16(s_q.wr.dead, s_q.wdata, wmask);
                OFS_TRIG_PRI: s_d.trig_pri = merge16(s_q.trig_pri, s_q.wdata, wmask);
                OFS_TRIG_SEC: s_d.trig_sec = merge16(s_q.trig_sec, s_q.wdata, wmask);
                OFS_TRIG_CTRL: s_d.trig_ctrl = merge16(s_q.trig_ctrl, s_q.wdata, wmask);
                OFS_IRQ_STATUS: s_d.status = s_q.status & ~s_q.wdata[IRQ_W-1:0];
                OFS_IRQ_MASK: s_d.mask = s_q.wdata[IRQ_W-1:0];
                OFS_STATE: s_d.bresp = RESP_OKAY;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        // read channel
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (s_axi_arvalid && !s_q.rvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            case (s_axi_araddr)
                OFS_MTB_CTRL: s_d.rdata[15:0] = s_q.mtb_ctrl;
                OFS_PERIOD: s_d.rdata[15:0] = s_q.wr.period;
                OFS_MASTER_DUTY: s_d.rdata[15:0] = s_q.master_duty;
                OFS_SEV_CMP: s_d.rdata[15:0] = s_q.sev_cmp;
                OFS_CH_CTRL: s_d.rdata[15:0] = s_q.chan_ctrl;
                OFS_CH_OUT_CTRL: s_d.rdata[15:0] = s_q.out_ctrl;
                OFS_CH_DUTY: s_d.rdata[15:0] = s_q.wr.duty;
                OFS_CH_PHASE: s_d.rdata[15:0] = s_q.wr.phase;
                OFS_DEAD_TIME: s_d.rdata[15:0] = s_q.wr.dead;
                OFS_TRIG_PRI: s_d.rdata[15:0] = s_q.trig_pri;
                OFS_TRIG_SEC: s_d.rdata[15:0] = s_q.trig_sec;
                OFS_TRIG_CTRL: s_d.rdata[15:0] = s_q.trig_ctrl;
                OFS_IRQ_STATUS: s_d.rdata[IRQ_W-1:0] = s_q.status;
                OFS_IRQ_MASK: s_d.rdata[IRQ_W-1:0] = s_q.mask;
                OFS_STATE: s_d.rdata[CW:0] = {s_q.pp_phase, s_q.cnt};
                default: s_d.rresp = RESP_SLVERR;
            endcase
        end

        // duty source chosen when loaded, so master duty follows the same update rule
        nd = s_q.chan_ctrl[CC_MDUTY_BIT] ? s_q.master_duty : s_q.wr.duty;
        if (s_q.chan_ctrl[CC_IUE_BIT])
        begin
            // at once; in complementary mode the dead-time unit still shapes the resulting edge
            s_d.act.duty = nd;
            s_d.act.phase = s_q.wr.phase;
            s_d.act.dead = s_q.wr.dead;
        end
        if (s_q.mtb_ctrl[MTB_IPU_BIT] && !rollover)
            s_d.act.period = s_q.wr.period;

        // time base
        if (!run)
        begin
            s_d.cnt = '0;
            s_d.pp_phase = 1'b0;
        end
        else if (rollover || ext_hit)
        begin
            s_d.cnt = '0;
            s_d.pp_phase = ~s_q.pp_phase;
            // all buffered values load together, duty zero included, so no stray pulse
            s_d.act = {s_q.wr.period, nd, s_q.wr.phase, s_q.wr.dead};
            if (s_q.mtb_ctrl[MTB_IPU_BIT])
                s_d.act.period = s_q.wr.period;
            if (s_q.chan_ctrl[CC_IUE_BIT])
                s_d.act.duty = nd;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end

        // triggers: compare on plain count, first start-count matches skipped
        s_d.trig = 1'b0;
        if (run && (s_q.cnt == s_q.trig_pri || s_q.cnt == s_q.trig_sec))
        begin
            ev[0] = 1'b1;
            if (s_q.start_cnt < s_q.trig_ctrl[TC_START_LO+:6])
            begin
                s_d.start_cnt = s_q.start_cnt + 6'h01;
            end
            else if (s_q.div_cnt >= s_q.trig_ctrl[TC_DIV_LO+:4])
            begin
                s_d.div_cnt = '0;
                s_d.trig = 1'b1;
            end
            else
            begin
                s_d.div_cnt = s_q.div_cnt + 4'h1;
            end
        end
        if (!run)
        begin
            s_d.div_cnt = '0;
            s_d.start_cnt = '0;
        end
        ev[1] = run && (s_q.cnt == s_q.sev_cmp);
        ev[2] = run && rollover;
        // set wins over a clearing write in the same cycle
        s_d.status = s_d.status | ev;
        s_d.irq = |(s_d.status & s_d.mask);

        // output shaping
        case (mode)
            HSPWM_REDUND: s_d.pins = {raw, raw};
            HSPWM_PUSHPULL: s_d.pins = {raw && !s_q.pp_phase, raw && s_q.pp_phase};
            default: s_d.pins = dt_pair;
        endcase
        // dead unit drains one clock late, so a stopped channel is forced low here
        if (!run)
            s_d.pins = '0;
        if (s_q.out_ctrl[OC_SWAP_BIT])
            s_d.pins = {s_d.pins.lo, s_d.pins.hi};
        // unsynced override acts next clock; synced waits for the boundary, or acts next clock while stopped
        if (s_q.out_ctrl[OC_OVEN_BIT] && (!s_q.out_ctrl[OC_OVSYNC_BIT] || rollover || !run))
            s_d.pins = s_q.out_ctrl[OC_OVD_LO+:2];
        else if (s_q.out_ctrl[OC_OVEN_BIT])
            s_d.pins = s_q.pins;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.wr.period <= PERIOD_RST;
            s_q.act.period <= PERIOD_RST;
        end
        else if (ce)
            s_q <= s_d;
    end

    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign high_output = s_q.pins.hi;
    assign low_output = s_q.pins.lo;
    assign trig_out = s_q.trig;
    assign irq = s_q.irq;

    stopped_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !run && !s_q.out_ctrl[OC_OVEN_BIT]) |=> !high_output && !low_output)
        else $error("outputs active while disabled");
    ext_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ext_hit) |=> s_q.cnt == '0) else $error("external reset missed");
    buffered_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !s_q.chan_ctrl[CC_IUE_BIT] && !rollover && !ext_hit && run) |=> $stable(s_q.act.duty))
        else $error("buffered duty changed mid period");
    immediate_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && s_q.chan_ctrl[CC_IUE_BIT] && !s_q.chan_ctrl[CC_MDUTY_BIT]) |=> s_q.act.duty == $past(s_q.wr.duty))
        else $error("immediate duty not applied");
    master_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && s_q.chan_ctrl[CC_IUE_BIT] && s_q.chan_ctrl[CC_MDUTY_BIT]) |=> s_q.act.duty == $past(s_q.master_duty))
        else $error("master duty not selected");
    redundant_same_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && mode == HSPWM_REDUND && !s_q.out_ctrl[OC_OVEN_BIT]) |=> high_output == low_output)
        else $error("redundant outputs differ");
    pushpull_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && mode == HSPWM_PUSHPULL && !s_q.out_ctrl[OC_OVEN_BIT]) |=> !(high_output && low_output))
        else $error("push-pull both high");
    override_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && s_q.out_ctrl[OC_OVEN_BIT] && !s_q.out_ctrl[OC_OVSYNC_BIT])
        |=> {high_output, low_output} == $past(s_q.out_ctrl[OC_OVD_LO+:2]))
        else $error("override late");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && run && s_q.cnt == s_q.sev_cmp) |=> s_q.status[1]) else $error("event not latched");
endmodule : hspwm_top
`default_nettype wire

//--- tb/hspwm_stage.sv
// power stage model: watches the gate pair for shoot-through, dead gaps and pulse order
`timescale 1ns/10ps
`default_nettype none
module hspwm_stage
(
    input wire logic aclk,
    input wire logic clr,
    input wire logic hi,
    input wire logic lo,
    output var int shoot,
    output var int min_gap,
    output var int alt_err
);
    int run;
    logic ph;
    logic pl;
    logic last;
    // a gate driver only listens, so nothing is ever driven back toward the block
    always @(posedge aclk)
    begin
        if (clr)
        begin
            shoot = 0;
            min_gap = 999;
            alt_err = 0;
            // a gap cut short by the clear must not count as a short one
            run = 999;
        end
        else
        begin
            if (hi && lo)
                shoot++;
            if ((hi && !ph) || (lo && !pl))
            begin
                if (run < min_gap)
                    min_gap = run;
                if ((hi && !ph && last) || (lo && !pl && !last))
                    alt_err++;
                last = hi;
            end
            run = (!hi && !lo) ? run + 1 : 0;
        end
        ph = hi;
        pl = lo;
    end
endmodule : hspwm_stage
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the pwm channel and its register port
`timescale 1ns/10ps
`default_nettype none
module tb;
    import hspwm_pkg::*;
    localparam int P = 101;
    logic aclk = 1'h0, aresetn = 1'h0, ext_reset = 1'h0, clr = 1'h1;
    logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
    logic [31:0] w_d = 32'h0, rdat, rd_v, lfsr = 32'h00010545;
    logic aw_r, w_r, b_v, ar_r, r_v, hi, lo, trg, irq;
    logic [1:0] bresp, rresp, rd_s;
    int error_cnt = 0, tests_run = 0, mh, ml, mr, mt, d, pr, shoot, gap, alt;

    always #50 aclk = ~aclk;

    hspwm_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .ext_reset(ext_reset),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .high_output(hi), .low_output(lo), .trig_out(trg), .irq(irq));
    hspwm_stage u_stage (.aclk(aclk), .clr(clr), .hi(hi), .lo(lo), .shoot(shoot), .min_gap(gap),
        .alt_err(alt));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task summarize;
        $display("mismatches %0d of %0d comparisons", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task hang;
        error_cnt++;
        summarize();
    endtask : hang

    task wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge aclk);
        aw_a <= a;
        aw_v <= 1'h1;
        w_d <= dv;
        w_v <= 1'h1;
        b_r <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (aw_v && aw_r)
                aw_v <= 1'h0;
            if (w_v && w_r)
                w_v <= 1'h0;
            if (b_v === 1'h1)
                break;
        end
        if (n == 50)
            hang();
        b_r <= 1'h0;
        chk(bresp, er);
    endtask : wr

    task rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'h1;
        r_r <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (ar_v && ar_r)
                ar_v <= 1'h0;
            if (r_v === 1'h1)
                break;
        end
        if (n == 50)
            hang();
        r_r <= 1'h0;
        rd_v = rdat;
        rd_s = rresp;
    endtask : rd

    task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        rd(a);
        chk(rd_v, e);
        chk(rd_s, er);
    endtask : rc

    // counts high cycles, rising edges and trigger pulses over n cycles
    task meas(input int n);
        logic ph, pl;
        ph = hi;
        pl = lo;
        mh = 0;
        ml = 0;
        mr = 0;
        mt = 0;
        repeat (n)
        begin
            @(posedge aclk);
            mh += int'(hi === 1'h1);
            ml += int'(lo === 1'h1);
            mr += int'((hi === 1'h1 && ph !== 1'h1) || (lo === 1'h1 && pl !== 1'h1));
            mt += int'(trg === 1'h1);
            ph = hi;
            pl = lo;
        end
    endtask : meas

    task lvl(input logic v);
        int n;
        for (n = 0; n < 400 && hi !== v; n++)
            @(posedge aclk);
        if (n == 400)
            hang();
    endtask : lvl

    // waiting for a pulse to end keeps later writes clear of rollover
    task fall;
        lvl(1'h1);
        lvl(1'h0);
    endtask : fall

    task clear;
        @(posedge aclk);
        clr <= 1'h1;
        @(posedge aclk);
        clr <= 1'h0;
    endtask : clear

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        clr <= 1'h0;
        rc(OFS_PERIOD, 32'h64);
        rc(OFS_IRQ_MASK, 32'h0);
        rc(8'h3C, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(OFS_CH_DUTY, 32'hABCD0032);
        rc(OFS_CH_DUTY, 32'h32);
        wr(OFS_CH_OUT_CTRL, 32'h400);
        meas(3 * P);
        chk(mh + ml, 0);
        wr(OFS_MTB_CTRL, 32'h8000);
        repeat (3)
        begin
            lfsr = nxt(lfsr);
            d = 1 + int'(lfsr % 90);
            wr(OFS_CH_DUTY, d);
            meas(2 * P);
            meas(2 * P);
            chk(mh, 2 * d);
            chk(ml, 2 * d);
        end
        wr(OFS_MASTER_DUTY, 32'h1E);
        wr(OFS_CH_CTRL, 32'h100);
        meas(2 * P);
        meas(2 * P);
        chk(mh, 60);
        wr(OFS_CH_CTRL, 32'h0);
        for (int m = 1; m < 3; m++)
        begin
            wr(OFS_CH_OUT_CTRL, 32'(m << OC_MODE_LO));
            wr(OFS_CH_DUTY, 32'hA);
            meas(3 * P);
            fall();
            wr(OFS_CH_DUTY, 32'h0);
            meas(3 * P);
            chk(mr, 0);
        end
        wr(OFS_CH_DUTY, 32'h14);
        meas(2 * P);
        clear();
        meas(4 * P);
        chk(mh, 40);
        chk(ml, 40);
        wr(OFS_MTB_CTRL, 32'h8400);
        pr = P;
        repeat (4)
        begin
            lfsr = nxt(lfsr);
            rd(OFS_STATE);
            d = pr - int'(rd_v[15:0]) - int'(lfsr[1:0]) - 2;
            meas(d < 0 ? 0 : d);
            pr = 81 + int'(lfsr[4:0]);
            wr(OFS_PERIOD, 32'(pr - 1));
            meas(2 * pr);
        end
        chk(alt, 0);
        wr(OFS_PERIOD, 32'h64);
        wr(OFS_MTB_CTRL, 32'h0);
        wr(OFS_CH_OUT_CTRL, 32'h400);
        wr(OFS_CH_CTRL, 32'h1);
        wr(OFS_MTB_CTRL, 32'h8000);
        wr(OFS_CH_DUTY, 32'hA);
        meas(2 * P);
        fall();
        wr(OFS_CH_DUTY, 32'h32);
        // pins trail the duty register by two clocks
        meas(2);
        meas(P);
        chk(mh, 50);
        wr(OFS_DEAD_TIME, 32'h5);
        wr(OFS_CH_OUT_CTRL, 32'h0);
        meas(2 * P);
        clear();
        repeat (6)
        begin
            lfsr = nxt(lfsr);
            wr(OFS_CH_DUTY, 32'hA + lfsr % 80);
            meas(int'(lfsr[5:0]));
        end
        wr(OFS_CH_CTRL, 32'h0);
        wr(OFS_CH_PHASE, 32'h2);
        meas(2 * P);
        wr(OFS_CH_PHASE, 32'h5F);
        meas(2 * P);
        wr(OFS_PERIOD, 32'h40);
        wr(OFS_CH_DUTY, 32'h14);
        wr(OFS_CH_PHASE, 32'h0);
        wr(OFS_DEAD_TIME, 32'h3);
        meas(3 * P);
        chk(shoot, 0);
        chk(gap >= 3, 1);
        wr(OFS_CH_OUT_CTRL, 32'h400);
        meas(130);
        meas(130);
        chk(mh, 40);
        wr(OFS_PERIOD, 32'h64);
        for (int k = 1; k < 3; k++)
        begin
            wr(OFS_CH_OUT_CTRL, 32'h410 | 32'(k << OC_OVD_LO));
            meas(3);
            meas(P);
            chk(mh, k == 2 ? P : 0);
            chk(ml, k == 1 ? P : 0);
        end
        wr(OFS_CH_OUT_CTRL, 32'h402);
        wr(OFS_CH_CTRL, 32'h2);
        meas(2 * P);
        fall();
        meas(20);
        ext_reset <= 1'h1;
        @(posedge aclk);
        ext_reset <= 1'h0;
        meas(6);
        chk(mr, 1);
        wr(OFS_TRIG_SEC, 32'hFFFF);
        wr(OFS_TRIG_PRI, 32'h3);
        for (int k = 0; k < 3; k++)
        begin
            wr(OFS_TRIG_CTRL, 32'(k << TC_DIV_LO));
            meas(12 * P);
            chk(mt, 12 / (k + 1));
        end
        wr(OFS_TRIG_PRI, 32'hFFFF);
        wr(OFS_TRIG_SEC, 32'h5);
        wr(OFS_TRIG_CTRL, 32'h1000);
        meas(12 * P);
        chk(mt, 6);
        wr(OFS_IRQ_MASK, 32'h1);
        meas(2);
        chk(irq, 1);
        wr(OFS_IRQ_MASK, 32'h0);
        meas(2);
        chk(irq, 0);
        wr(OFS_TRIG_SEC, 32'hFFFF);
        meas(2 * P);
        wr(OFS_IRQ_STATUS, 32'h1);
        rd(OFS_IRQ_STATUS);
        chk(rd_v[1:0], 2'h2);
        summarize();
    end

    initial
    begin
        #5000000;
        hang();
    end
endmodule : tb
`default_nettype wire
